// File: rtl/srpcs_pkg.sv
package srpcs_pkg;
   localparam int NPORTS     = 4;
   localparam int LINK_PORTS = 2;
   localparam int BUS_PORTS  = 1;
   localparam int PNUM_W     = 5;
   localparam int ADDR_W     = 12;
   localparam int DATA_W     = 32;
   localparam int BUF_DEPTH  = 2;

   // Register map
   localparam logic [ADDR_W-1:0] CTRL_BLK   = 12'h800;
   localparam logic [ADDR_W-1:0] STAT_BLK   = 12'h880;
   localparam logic [ADDR_W-1:0] RELOAD_BLK = 12'h900;
   localparam logic [ADDR_W-1:0] RCFG_ADDR  = 12'ha00;
   localparam logic [ADDR_W-1:0] PRESC_ADDR = 12'ha14;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 6;
   localparam int BLK_LSB = 7;

   // Port control fields
   localparam int DIV_LSB = 24;
   localparam int DIV_MSB = 31;
   localparam int B_AUTOSEL = 13;
   localparam int B_MANSEL  = 12;
   localparam int B_BRIDGE  = 11;
   localparam int B_OFF     = 10;
   localparam int B_TIMER   = 9;
   localparam int B_PRIO    = 8;
   localparam int B_FLUSH   = 7;
   localparam int B_DISCARD = 6;
   localparam int B_TCODE   = 5;
   localparam int B_CFGACC  = 3;
   localparam int B_ASTART  = 2;
   localparam int B_GO      = 1;
   localparam int B_LOFF    = 0;
   localparam logic [7:0] DIV_RESET = 8'h01;

   // Port status fields
   localparam int KIND_LSB = 30;
   localparam int KIND_MSB = 31;
   localparam int B_TS     = 18;
   localparam int B_MEMERR = 17;
   localparam int B_TXFULL = 16;
   localparam int B_RXEMPT = 15;
   localparam int LST_LSB  = 12;
   localparam int LST_MSB  = 14;
   localparam int SRC_LSB  = 7;
   localparam int SRC_MSB  = 11;
   localparam int B_TXACT  = 6;
   localparam int B_RXBUSY = 5;
   localparam int B_BADADR = 4;
   localparam int B_CREDIT = 3;
   localparam int B_ESC    = 2;
   localparam int B_DISC   = 1;
   localparam int B_PAR    = 0;
   localparam int B_ERRCLR = 24;
   localparam int ERR_LSB  = 20;
   localparam int ERR_MSB  = 23;
   localparam logic [1:0] KIND_LINK = 2'h0;
   localparam logic [1:0] KIND_BUS  = 2'h1;

   // Reload, prescaler and router configuration
   localparam int RELOAD_W = 10;
   localparam logic [RELOAD_W-1:0] RELOAD_MIN   = 10'h001;
   localparam logic [RELOAD_W-1:0] RELOAD_RESET = 10'h3ff;
   localparam int PRESC_W = 16;
   localparam logic [PRESC_W-1:0] PRESC_MIN = 16'h00fa;
   localparam int NLINK_LSB = 27;
   localparam int NLINK_MSB = 31;
   localparam int NBUS_LSB  = 22;
   localparam int NBUS_MSB  = 26;

   typedef enum logic {SEL_PRIMARY = 1'b0, SEL_REDUNDANT = 1'b1} srpcs_sel_e;

   typedef struct packed {
      logic [7:0] divisor;
      logic       autoSel;
      logic       manualSel;
      logic       bridgeBit;
      logic       portOff;
      logic       timerOn;
      logic       priorityHigh;
      logic       timecodeOn;
      logic       cfgAccessOn;
      logic       autostart;
      logic       linkGo;
      logic       linkOff;
   } srpcs_ctrl_s;

   typedef struct packed {
      logic              creditErr;
      logic              escErr;
      logic              discErr;
      logic              parErr;
      logic              badAddr;
      logic              fifoParity;
      logic              txFull;
      logic              rxEmpty;
      logic              txActive;
      logic              rxBusy;
      logic [PNUM_W-1:0] srcPort;
      logic [2:0]        linkState;
      logic              rxTimecode;
      logic              tickIn;
   } srpcs_pin_s;

   typedef struct packed {
      srpcs_sel_e activeSel;
      logic       txFlush;
      logic       rxDiscard;
      logic       tickOut;
      logic       tcSend;
      logic       timeoutSpill;
   } srpcs_evt_s;
endpackage : srpcs_pkg

// File: rtl/srpcs_port_ctrl.sv
// How it works
// RL1 - Run-state divisor in control 31:24, resets to 1, zero on non-link ports
// RL2 - Auto-select bit picks redundant port by incoming activity, else manual bit
// RL3 - Manual select chooses primary or redundant only while auto select is off
// RL4 - Disable bit flags port off so fabric spills and skips it
// RL5 - Transfer timeout timer runs only while timer enable bit is set
// RL6 - Bit 8 gives path arbitration priority, one is high
// RL7 - Writing one to bit 7 pulses a transmit FIFO flush
// RL8 - Writing one to bit 6 discards active reception, link ports only
// RL9 - Time-code enable gates tick-out, forwarding and time-code transmission
// RL10 - Cleared config access bit makes fabric spill packets to config port
// RL11 - Autostart, link start, link disable on link ports, zero elsewhere
// RL12 - Config status keeps latest nonzero status code, bit 24 clears it
// RL13 - Timeout spill flag set on timer expiry, write one clears
// RL14 - Config status bits 11:7 show port accessing the config port
// RL15 - Status bits 31:30 give port kind, 00 link, 01 bus
// RL16 - Sticky FIFO parity fault flag, write one clears
// RL17 - Transmit FIFO full and receive FIFO empty flags, latter link only
// RL18 - Link state in bits 14:12, zero on non-link ports
// RL19 - Transmit busy, receive busy and source port while transmitting
// RL20 - Sticky bad address and link-only credit, escape, disconnect, parity flags
// RL21 - Ten-bit timeout reload in ticks, zero written stores one
// RL22 - Router config reports link and bus port counts read-only
// RL23 - Write-one-clear flags read back and clear only on written ones
// RL24 - Common tick every prescaler plus one core cycles
// RL25 - Zero writes keep flags, a same-cycle event beats the clear
`timescale 1ns/1ps
module srpcs_port_ctrl
   import srpcs_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   input  wire logic                     reqValid,
   output logic                          reqReady,
   input  wire logic                     reqWrite,
   input  wire logic [ADDR_W-1:0]        reqAddr,
   input  wire logic [DATA_W-1:0]        reqData,
   output logic                          rspValid,
   input  wire logic                     rspReady,
   output logic [DATA_W-1:0]             rspData,
   input  wire srpcs_pin_s [NPORTS-1:0]  portIn,
   input  wire logic [NPORTS-1:0]        actPrimaryPin,
   input  wire logic [NPORTS-1:0]        actRedundantPin,
   input  wire logic                     cfgStatusValid,
   input  wire logic [3:0]               cfgStatusCode,
   input  wire logic [PNUM_W-1:0]        cfgAccessor,
   output srpcs_ctrl_s [NPORTS-1:0]      portCtrl,
   output srpcs_evt_s [NPORTS-1:0]       portEvt,
   output logic                          timeTick
);

   ////////////////////////////////////////////////////////////////////////
   // Request decode

   logic                 reqTake;
   logic                 wrTake;
   logic [PNUM_W-1:0]    reqIdx;
   logic                 inCtrl;
   logic                 inStat;
   logic                 inReload;
   logic                 prescHit;
   logic [DATA_W-1:0]    rdWord;
   logic [PRESC_W-1:0]   presc_reg;
   logic [PRESC_W-1:0]   prescCnt_reg;
   logic [3:0]           last_status_code_reg;
   logic [NPORTS-1:0]    anyTickOut;
   logic                 forward;

   logic [DATA_W-1:0]    ctrlWord   [NPORTS];
   logic [DATA_W-1:0]    statWord   [NPORTS];
   logic [DATA_W-1:0]    reloadWord [NPORTS];

   assign reqTake  = reqValid && reqReady;
   assign wrTake   = reqTake && reqWrite;
   assign reqIdx   = reqAddr[IDX_MSB:IDX_LSB];
   assign inCtrl   = reqAddr[ADDR_W-1:BLK_LSB] == CTRL_BLK[ADDR_W-1:BLK_LSB];
   assign inStat   = reqAddr[ADDR_W-1:BLK_LSB] == STAT_BLK[ADDR_W-1:BLK_LSB];
   assign inReload = reqAddr[ADDR_W-1:BLK_LSB] == RELOAD_BLK[ADDR_W-1:BLK_LSB];
   assign prescHit = reqAddr == PRESC_ADDR;
   assign forward  = |anyTickOut;

   ////////////////////////////////////////////////////////////////////////
   // Prescaler tick

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         presc_reg <= PRESC_MIN;
      end else if (wrTake && prescHit) begin
         presc_reg <= (reqData[PRESC_W-1:0] < PRESC_MIN) ? PRESC_MIN : reqData[PRESC_W-1:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prescCnt_reg <= '0;
         timeTick     <= 1'b0;
      end else if (prescCnt_reg == '0) begin
         prescCnt_reg <= presc_reg; // RL24
         timeTick     <= 1'b1;
      end else begin
         prescCnt_reg <= prescCnt_reg - 16'h0001;
         timeTick     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration port status code

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         last_status_code_reg <= 4'h0;
      end else if (cfgStatusValid && cfgStatusCode != 4'h0) begin
         last_status_code_reg <= cfgStatusCode; // RL12
      end else if (wrTake && inStat && reqIdx == '0 && reqData[B_ERRCLR]) begin
         last_status_code_reg <= 4'h0; // RL12
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-port logic

   for (genvar i = 0; i < NPORTS; i++) begin : g_port
      localparam bit IS_LINK = (i >= 1) && (i <= LINK_PORTS);
      localparam bit IS_CFG  = (i == 0);
      localparam logic [DATA_W-1:0] W1C_MASK = IS_CFG ? (32'h1 << B_TS) :
         IS_LINK ? ((32'h1 << B_TS) | (32'h1 << B_MEMERR) | (32'h1 << B_BADADR) | (32'h1 << B_CREDIT) |
                    (32'h1 << B_ESC) | (32'h1 << B_DISC) | (32'h1 << B_PAR)) :
                   ((32'h1 << B_TS) | (32'h1 << B_MEMERR) | (32'h1 << B_BADADR));

      logic                wrCtrl;
      logic                wrStat;
      logic                wrReload;
      logic [1:0]          actPriSync_reg;
      logic [1:0]          actRedSync_reg;
      logic [RELOAD_W-1:0] reload_reg;
      logic [RELOAD_W-1:0] tmr_reg;
      logic                tmrRun;
      logic                expire;
      logic [DATA_W-1:0]   sticky_reg;
      logic [DATA_W-1:0]   evWord;
      logic [DATA_W-1:0]   clrWord;
      srpcs_ctrl_s         c;
      srpcs_pin_s          p;

      assign wrCtrl   = wrTake && inCtrl && reqIdx == PNUM_W'(i);
      assign wrStat   = wrTake && inStat && reqIdx == PNUM_W'(i);
      assign wrReload = wrTake && inReload && reqIdx == PNUM_W'(i);
      assign c        = portCtrl[i];
      assign p        = portIn[i];

      // Control register
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            portCtrl[i]             <= '0;
            portCtrl[i].divisor     <= IS_LINK ? DIV_RESET : 8'h00; // RL1
            portCtrl[i].timecodeOn  <= !IS_CFG;
            portCtrl[i].cfgAccessOn <= !IS_CFG;
            portCtrl[i].autostart   <= IS_LINK;
         end else if (wrCtrl) begin
            portCtrl[i].timerOn <= reqData[B_TIMER]; // RL5
            if (!IS_CFG) begin
               portCtrl[i].bridgeBit    <= reqData[B_BRIDGE];
               portCtrl[i].portOff      <= reqData[B_OFF]; // RL4
               portCtrl[i].priorityHigh <= reqData[B_PRIO]; // RL6
               portCtrl[i].timecodeOn   <= reqData[B_TCODE]; // RL9
               portCtrl[i].cfgAccessOn  <= reqData[B_CFGACC]; // RL10
            end
            if (IS_LINK) begin
               portCtrl[i].divisor   <= reqData[DIV_MSB:DIV_LSB]; // RL1
               portCtrl[i].autoSel   <= reqData[B_AUTOSEL]; // RL2
               portCtrl[i].manualSel <= reqData[B_MANSEL]; // RL3
               portCtrl[i].autostart <= reqData[B_ASTART]; // RL11
               portCtrl[i].linkGo    <= reqData[B_GO]; // RL11
               portCtrl[i].linkOff   <= reqData[B_LOFF]; // RL11
            end
         end
      end

      assign ctrlWord[i] = {c.divisor, 10'h000, c.autoSel, c.manualSel, c.bridgeBit, c.portOff, c.timerOn,
                            c.priorityHigh, 2'b00, c.timecodeOn, 1'b0, c.cfgAccessOn, c.autostart,
                            c.linkGo, c.linkOff};

      // Two-flop sync of activity pins
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            actPriSync_reg <= 2'b00;
            actRedSync_reg <= 2'b00;
         end else begin
            actPriSync_reg <= {actPriSync_reg[0], actPrimaryPin[i]};
            actRedSync_reg <= {actRedSync_reg[0], actRedundantPin[i]};
         end
      end

      // Redundant pair selection
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            portEvt[i].activeSel <= SEL_PRIMARY;
         end else if (!IS_LINK) begin
            portEvt[i].activeSel <= SEL_PRIMARY;
         end else if (!c.autoSel) begin
            portEvt[i].activeSel <= srpcs_sel_e'(c.manualSel); // RL3
         end else if (actPriSync_reg[1]) begin
            portEvt[i].activeSel <= SEL_PRIMARY; // RL2
         end else if (actRedSync_reg[1]) begin
            portEvt[i].activeSel <= SEL_REDUNDANT; // RL2
         end
      end

      // Command pulses and time-code gating
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            portEvt[i].txFlush   <= 1'b0;
            portEvt[i].rxDiscard <= 1'b0;
            portEvt[i].tickOut   <= 1'b0;
            portEvt[i].tcSend    <= 1'b0;
         end else begin
            portEvt[i].txFlush   <= !IS_CFG && wrCtrl && reqData[B_FLUSH]; // RL7
            portEvt[i].rxDiscard <= IS_LINK && wrCtrl && reqData[B_DISCARD] && p.rxBusy; // RL8
            portEvt[i].tickOut   <= !IS_CFG && c.timecodeOn && p.rxTimecode; // RL9
            portEvt[i].tcSend    <= !IS_CFG && c.timecodeOn && (p.tickIn || (forward && !anyTickOut[i])); // RL9
         end
      end

      assign anyTickOut[i] = portEvt[i].tickOut;

      // Timeout reload and timer
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            reload_reg <= RELOAD_RESET;
         end else if (wrReload) begin
            reload_reg <= (reqData[RELOAD_W-1:0] == '0) ? RELOAD_MIN : reqData[RELOAD_W-1:0]; // RL21
         end
      end

      assign reloadWord[i] = {{(DATA_W-RELOAD_W){1'b0}}, reload_reg};
      assign tmrRun        = c.timerOn && (p.txActive || p.rxBusy); // RL5
      assign expire        = tmrRun && timeTick && tmr_reg == RELOAD_MIN;

      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            tmr_reg <= RELOAD_RESET;
         end else if (!tmrRun || expire) begin
            tmr_reg <= reload_reg;
         end else if (timeTick) begin
            tmr_reg <= tmr_reg - RELOAD_MIN; // RL24
         end
      end

      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            portEvt[i].timeoutSpill <= 1'b0;
         end else begin
            portEvt[i].timeoutSpill <= expire;
         end
      end

      // Sticky flags, set beats clear
      always_comb begin
         evWord           = '0;
         evWord[B_TS]     = expire; // RL13
         evWord[B_MEMERR] = p.fifoParity; // RL16
         evWord[B_BADADR] = p.badAddr; // RL20
         evWord[B_CREDIT] = p.creditErr;
         evWord[B_ESC]    = p.escErr;
         evWord[B_DISC]   = p.discErr;
         evWord[B_PAR]    = p.parErr;
      end

      assign clrWord = wrStat ? (reqData & W1C_MASK) : '0; // RL23

      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            sticky_reg <= '0;
         end else begin
            sticky_reg <= ((sticky_reg & ~clrWord) | evWord) & W1C_MASK; // RL25
         end
      end

      // Status word
      always_comb begin
         statWord[i] = sticky_reg;
         if (IS_CFG) begin
            statWord[i][ERR_MSB:ERR_LSB] = last_status_code_reg; // RL12
            statWord[i][SRC_MSB:SRC_LSB] = cfgAccessor; // RL14
         end else begin
            statWord[i][KIND_MSB:KIND_LSB] = IS_LINK ? KIND_LINK : KIND_BUS; // RL15
            statWord[i][B_TXFULL]          = p.txFull; // RL17
            statWord[i][B_RXEMPT]          = IS_LINK && p.rxEmpty; // RL17
            statWord[i][LST_MSB:LST_LSB]   = IS_LINK ? p.linkState : 3'b000; // RL18
            statWord[i][SRC_MSB:SRC_LSB]   = p.srcPort; // RL19
            statWord[i][B_TXACT]           = p.txActive; // RL19
            statWord[i][B_RXBUSY]          = p.rxBusy; // RL19
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux

   always_comb begin
      rdWord = '0;
      if (reqIdx < PNUM_W'(NPORTS)) begin
         if (inCtrl) begin
            rdWord = ctrlWord[reqIdx[1:0]];
         end else if (inStat) begin
            rdWord = statWord[reqIdx[1:0]];
         end else if (inReload) begin
            rdWord = reloadWord[reqIdx[1:0]];
         end
      end
      if (reqAddr == RCFG_ADDR) begin
         rdWord[NLINK_MSB:NLINK_LSB] = PNUM_W'(LINK_PORTS); // RL22
         rdWord[NBUS_MSB:NBUS_LSB]   = PNUM_W'(BUS_PORTS); // RL22
      end else if (prescHit) begin
         rdWord = {{(DATA_W-PRESC_W){1'b0}}, presc_reg};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-entry read answer buffer

   logic [DATA_W-1:0] buf_reg [BUF_DEPTH];
   logic              wrPtr_reg;
   logic              rdPtr_reg;
   logic [1:0]        count_reg;
   logic              push;
   logic              pop;

   assign push     = reqTake && !reqWrite;
   assign pop      = rspValid && rspReady;
   assign rspData  = buf_reg[rdPtr_reg];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         buf_reg[0] <= '0;
         buf_reg[1] <= '0;
      end else if (push) begin
         buf_reg[wrPtr_reg] <= rdWord;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wrPtr_reg <= 1'b0;
         rdPtr_reg <= 1'b0;
         count_reg <= 2'd0;
         rspValid  <= 1'b0;
         reqReady  <= 1'b1;
      end else begin
         if (push) begin
            wrPtr_reg <= ~wrPtr_reg;
         end
         if (pop) begin
            rdPtr_reg <= ~rdPtr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
         rspValid  <= (count_reg + {1'b0, push} - {1'b0, pop}) != 2'd0;
         reqReady  <= (count_reg + {1'b0, push} - {1'b0, pop}) != 2'd2;
      end
   end

endmodule : srpcs_port_ctrl

// File: verification/srpcs_port_ctrl_properties.sv
`timescale 1ns/1ps
module srpcs_port_ctrl_properties
   import srpcs_pkg::*;
(
   input wire logic                     core_clk,
   input wire logic                     rst,
   input wire logic                     reqValid,
   input wire logic                     reqReady,
   input wire logic                     reqWrite,
   input wire logic [ADDR_W-1:0]        reqAddr,
   input wire logic [DATA_W-1:0]        reqData,
   input wire logic                     rspValid,
   input wire logic                     rspReady,
   input wire logic [DATA_W-1:0]        rspData,
   input wire srpcs_pin_s [NPORTS-1:0]  portIn,
   input wire srpcs_ctrl_s [NPORTS-1:0] portCtrl,
   input wire srpcs_evt_s [NPORTS-1:0]  portEvt,
   input wire logic                     timeTick
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   logic ctrl1Wr;
   assign ctrl1Wr = reqValid && reqReady && reqWrite && reqAddr == CTRL_BLK + 12'h004;
   ////////////////////////////////////////////////////////////////////////
   AST_RD_ANSWER: assert property (reqValid && reqReady && !reqWrite |=> rspValid)
      else $error("read answer missing");
   AST_RSP_STAND: assert property (rspValid && !rspReady |=> rspValid && $stable(rspData))
      else $error("answer dropped early");
   AST_REFUSE_FULL: assert property (!reqReady |-> rspValid)
      else $error("refused with nothing held");
   AST_TICK_GAP: assert property (timeTick |=> !timeTick [*8])
      else $error("tick gap too short");
   AST_FLUSH: assert property (ctrl1Wr && reqData[B_FLUSH] |=> portEvt[1].txFlush)
      else $error("flush pulse missing");
   AST_DISCARD: assert property (ctrl1Wr && reqData[B_DISCARD] |=> portEvt[1].rxDiscard == $past(portIn[1].rxBusy))
      else $error("discard pulse wrong");
   AST_BUS_NO_DISCARD: assert property (!portEvt[3].rxDiscard)
      else $error("discard on bus port");
   AST_TICKOUT: assert property (##1 portEvt[1].tickOut == ($past(portIn[1].rxTimecode) && $past(portCtrl[1].timecodeOn)))
      else $error("tick out wrong");
   AST_TIMEOUT: assert property (portEvt[1].timeoutSpill |-> $past(timeTick) && $past(portCtrl[1].timerOn))
      else $error("spill without tick or timer");
   AST_MANSEL: assert property ((!portCtrl[1].autoSel && $stable(portCtrl[1].manualSel)) [*3] |-> portEvt[1].activeSel == portCtrl[1].manualSel)
      else $error("manual select ignored");
   COV_REFUSE: cover property (!reqReady);
   COV_FLUSH: cover property (portEvt[1].txFlush);
   COV_SPILL: cover property (portEvt[1].timeoutSpill);
   COV_TICKOUT: cover property (portEvt[1].tickOut);
endmodule : srpcs_port_ctrl_properties

bind srpcs_port_ctrl srpcs_port_ctrl_properties chk_u (.core_clk, .rst, .reqValid, .reqReady, .reqWrite,
   .reqAddr, .reqData, .rspValid, .rspReady, .rspData, .portIn, .portCtrl, .portEvt, .timeTick);

// File: verification/srpcs_far_model.sv
`timescale 1ns/1ps
module srpcs_far_model
   import srpcs_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   input  wire logic [DATA_W-1:0]        lvl,
   input  wire logic [NPORTS-1:0]        fault,
   input  wire srpcs_ctrl_s [NPORTS-1:0] portCtrl,
   output srpcs_pin_s [NPORTS-1:0]       portIn
);
   // Six level bits per port, one byte apart; a fault pulses all error lines
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         portIn <= '0;
      end else begin
         for (int p = 0; p < NPORTS; p++) begin
            portIn[p].txFull     <= lvl[8*p];
            portIn[p].rxEmpty    <= lvl[8*p+1];
            portIn[p].txActive   <= lvl[8*p+2];
            portIn[p].rxBusy     <= lvl[8*p+3];
            portIn[p].rxTimecode <= lvl[8*p+4];
            portIn[p].tickIn     <= lvl[8*p+5];
            portIn[p].srcPort    <= lvl[8*p+2] ? PNUM_W'(NPORTS-1-p) : '0;
            portIn[p][19:14]     <= {6{fault[p]}};
            // Bus port state must be masked
            if (p > LINK_PORTS)
               portIn[p].linkState <= 3'h5;
            else if (portCtrl[p].linkOff)
               portIn[p].linkState <= 3'h0;
            else if (portCtrl[p].linkGo && portIn[p].linkState != 3'h5)
               portIn[p].linkState <= portIn[p].linkState + 3'h1;
         end
      end
   end
endmodule : srpcs_far_model

// File: verification/srpcs_port_ctrl_tb.sv
`timescale 1ns/1ps
module srpcs_port_ctrl_tb;
   import srpcs_pkg::*;
   logic                     core_clk, rst, reqValid, reqReady, reqWrite, rspValid, rspReady, timeTick;
   logic                     cfgStatusValid, churn, stall;
   logic [ADDR_W-1:0]        reqAddr, sa;
   logic [DATA_W-1:0]        reqData, rspData, lvl, d;
   logic [NPORTS-1:0]        actPrimaryPin, actRedundantPin, fault;
   logic [3:0]               cfgStatusCode;
   logic [PNUM_W-1:0]        cfgAccessor;
   srpcs_pin_s [NPORTS-1:0]  portIn;
   srpcs_ctrl_s [NPORTS-1:0] portCtrl;
   srpcs_evt_s [NPORTS-1:0]  portEvt;
   logic [DATA_W-1:0]        expQ[$];
   logic [DATA_W-1:0]        mask[NPORTS] = '{32'h00000200, 32'hff003f2f, 32'hff003f2f, 32'h00000f28};
   int                       n_mismatch, total_checks, p;
   integer                   seed = 32'h0d4835fe;

   srpcs_port_ctrl dut_u (.core_clk, .rst, .reqValid, .reqReady, .reqWrite, .reqAddr, .reqData, .rspValid,
      .rspReady, .rspData, .portIn, .actPrimaryPin, .actRedundantPin, .cfgStatusValid, .cfgStatusCode,
      .cfgAccessor, .portCtrl, .portEvt, .timeTick);
   srpcs_far_model far_u (.core_clk, .rst, .lvl, .fault, .portCtrl, .portIn);
   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic check(input logic [31:0] got, want);
      total_checks++;
      if (got !== want) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h want %h", $time, got, want);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   // One access; a read queues its expected answer
   task automatic busXfer(input logic w, input logic [11:0] a, input logic [31:0] v);
      @(negedge core_clk);
      reqWrite = w;
      reqAddr  = a;
      reqData  = w ? v : '0;
      reqValid = 1'b1;
      if (!w)
         expQ.push_back(v);
      while (reqReady !== 1'b1) @(negedge core_clk);
      @(negedge core_clk);
      reqValid = 1'b0;
   endtask : busXfer

   function automatic logic [31:0] expStatus(input int q, input logic [31:0] s);
      s[SRC_MSB:SRC_LSB] = q == 0 ? cfgAccessor : portIn[q].srcPort;
      if (q > 0) begin
         s[KIND_MSB:KIND_LSB] = q > LINK_PORTS ? KIND_BUS : KIND_LINK;
         s[B_TXFULL] = portIn[q].txFull;
         s[B_TXACT]  = portIn[q].txActive;
         s[B_RXBUSY] = portIn[q].rxBusy;
         if (q <= LINK_PORTS) begin
            s[B_RXEMPT] = portIn[q].rxEmpty;
            s[LST_MSB:LST_LSB] = portIn[q].linkState;
         end
      end
      return s;
   endfunction : expStatus

   always @(posedge core_clk) begin
      if (rspValid === 1'b1 && rspReady === 1'b1)
         check(rspData, expQ.pop_front());
   end

   always @(negedge core_clk) begin
      rspReady <= !stall && $random(seed) % 2 != 0;
      {actPrimaryPin, actRedundantPin} <= 8'($random(seed));
      if (churn)
         lvl <= $random(seed);
   end

   initial begin
      #(40 * 20000);
      n_mismatch++;
      give_verdict();
   end

   initial begin
      {rst, churn, stall} = 3'b100;
      {reqValid, reqWrite, cfgStatusValid} = '0;
      {reqAddr, reqData, lvl, fault, cfgStatusCode, cfgAccessor} = '0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      for (int q = 0; q < NPORTS; q++) begin
         busXfer(0, CTRL_BLK + 12'(4*q), q == 0 ? 0 : q == 3 ? 32'h28 : 32'h0100002c);
         busXfer(0, STAT_BLK + 12'(4*q), expStatus(q, 0));
         busXfer(0, RELOAD_BLK + 12'(4*q), 32'h3ff);
      end
      busXfer(0, RCFG_ADDR, 32'h10400000);
      busXfer(0, PRESC_ADDR, 32'hfa);
      busXfer(0, 12'ha08, 0);
      busXfer(0, CTRL_BLK + 12'h10, 0);
      $display("reset values done");
      churn = 1'b1;
      repeat (12) begin
         p = $random(seed) & 3;
         d = $random(seed);
         busXfer(1, CTRL_BLK + 12'(4*p), d);
         busXfer(0, CTRL_BLK + 12'(4*p), d & mask[p]);
      end
      churn = 1'b0;
      @(negedge core_clk);
      lvl = 32'h0f0f0f0f;
      repeat (8) @(negedge core_clk);
      $display("control fields done");
      for (int q = 1; q < NPORTS; q++) begin
         sa = STAT_BLK + 12'(4*q);
         d  = q == 3 ? 32'h20010 : 32'h2001f;
         busXfer(1, sa, '1);
         fault[q] = 1'b1;
         @(negedge core_clk);
         fault[q] = 1'b0;
         busXfer(0, sa, expStatus(q, d));
         busXfer(1, sa, 0);
         busXfer(0, sa, expStatus(q, d));
         busXfer(1, sa, 32'h0002001f);
         busXfer(0, sa, expStatus(q, 0));
      end
      {cfgAccessor, cfgStatusCode, cfgStatusValid} = {5'h13, 4'ha, 1'b1};
      @(negedge core_clk) cfgStatusCode = 4'h0;
      @(negedge core_clk) cfgStatusValid = 1'b0;
      busXfer(0, STAT_BLK, expStatus(0, 32'h00a00000));
      busXfer(1, STAT_BLK, 32'h01000000);
      busXfer(0, STAT_BLK, expStatus(0, 0));
      $display("status flags done");
      busXfer(1, PRESC_ADDR, 32'h10);
      busXfer(0, PRESC_ADDR, 32'hfa);
      busXfer(1, RELOAD_BLK + 12'h4, 0);
      busXfer(0, RELOAD_BLK + 12'h4, 32'h1);
      busXfer(1, CTRL_BLK + 12'h4, 32'h010000ee);
      busXfer(1, STAT_BLK + 12'h4, 32'h00040000);
      repeat (510) @(negedge core_clk);
      busXfer(0, STAT_BLK + 12'h4, expStatus(1, 0));
      busXfer(1, CTRL_BLK + 12'h4, 32'h0100022e);
      repeat (510) @(negedge core_clk);
      busXfer(0, STAT_BLK + 12'h4, expStatus(1, 32'h00040000));
      $display("timeout done");
      stall = 1'b1;
      repeat (2) @(negedge core_clk);
      fork
         repeat (3) busXfer(0, RCFG_ADDR, 32'h10400000);
         begin
            repeat (12) @(negedge core_clk);
            check(32'(reqReady), 0);
            stall = 1'b0;
         end
      join
      repeat (10) @(negedge core_clk);
      check(expQ.size(), 0);
      $display("buffer done");
      give_verdict();
   end
endmodule : srpcs_port_ctrl_tb
